//--- usrc_pkg.sv
// Package of constants and carriers for the UART sleep and RS-485 control
// Behaviour
// - Automatic sleep allowed only while enhanced-functions and sleep enable are both set.
// - With idle-ignore clear, receive line must stay high four character times first.
// - With idle-ignore set, receive line state is ignored for sleep entry.
// - Sleep needs quiet modem inputs, empty transmit path, no interrupt, empty receive FIFO.
// - While asleep the UART clock and baud clock are both stopped.
// - Wake on receive start bit, transmit FIFO write, or any modem input change.
// - After waking, re-enter sleep when conditions hold again, until sleep enable clears.
// - Low-power pin high stops all clocks and isolates host inputs until released.
// - RTS follows modem control bit or flow control; auto mode hands it to transmitter.
// - Auto RS-485 mode without inversion drives RTS low once host writes data.
// - Inversion drives RTS high while transmitter has data, low after last bit.
// - Multidrop enable treats received characters with ninth bit one as addresses.
// - Normal multidrop with forced parity zero drops data bytes while receiver disabled.
// - Normal multidrop address byte sets parity error, enters FIFO, raises line interrupt.
// - Host enables receiver for its own address; later addresses again flag parity error.
// - Auto address mode discards data and addresses not equal to match character.
// - Matching address enables receiver, is stored with ninth bit, raises line interrupt.
// - Enabled receiver disables and drops on mismatching address, stores matching one.
package usrc_pkg;

  localparam int USRC_IDLE_CHARS = 4;
  localparam int USRC_MODEM_W = 4;
  localparam int USRC_CHAR_W = 8;
  localparam logic [2:0] USRC_LCR_FORCE0 = 3'h7;
  localparam logic USRC_RESET_RTS_N = 1'h1;

  typedef enum {
    USRC_ST_RUN,
    USRC_ST_SLEEP,
    USRC_ST_LOW_POWER_PIN
  } usrc_state_t;

  typedef struct packed {
    logic [USRC_CHAR_W-1:0] data;
    logic ninth;
  } usrc_rx_char_t;

  typedef struct packed {
    logic [USRC_CHAR_W-1:0] data;
    logic perr;
  } usrc_push_t;

  typedef struct packed {
    logic enh_functions_en;
    logic sleep_en;
    logic rx_idle_ignore;
    logic spec_char_en;
    logic multidrop_en;
    logic rts_auto_en;
    logic rts_invert;
    logic line_irq_en;
    logic [2:0] parity_mode;
  } usrc_cfg_t;

endpackage : usrc_pkg

//--- usrc_idle_timer.sv
// Counts whole character times of an idle-high receive line
module usrc_idle_timer #(
  parameter int IDLE_CHARS = usrc_pkg::USRC_IDLE_CHARS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_line,
  input wire logic char_tick,
  output logic rx_idle
);
  import usrc_pkg::*;

  localparam int CW = $clog2(IDLE_CHARS + 1);
  localparam logic [CW-1:0] FULL = CW'(IDLE_CHARS);

  if (IDLE_CHARS < 1) begin : g_chk
    $error("usrc_idle_timer: IDLE_CHARS must be at least one");
  end

  logic [CW-1:0] count_reg;

  // Restart on any low level, saturate at the threshold
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (!rx_line) begin
      count_reg <= '0;
    end else if (char_tick && count_reg != FULL) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  assign rx_idle = rx_line && (count_reg == FULL);

endmodule : usrc_idle_timer

//--- usrc_ctrl.sv
// Sleep, low-power, RS-485 RTS and multidrop address control
module usrc_ctrl #(
  parameter int IDLE_CHARS = usrc_pkg::USRC_IDLE_CHARS
) (
  input wire logic clk,
  input wire logic resetn,
  input usrc_pkg::usrc_cfg_t cfg,
  input wire logic low_power_pin,
  input wire logic [usrc_pkg::USRC_MODEM_W-1:0] modem_in,
  input wire logic rx_line,
  input wire logic char_tick,
  input wire logic tx_write,
  input wire logic tx_fifo_empty,
  input wire logic tsr_empty,
  input wire logic irq_pending,
  input wire logic rx_fifo_empty,
  input wire logic mcr_rts,
  input wire logic hw_flow_en,
  input wire logic hw_flow_rts_n,
  input wire logic [usrc_pkg::USRC_CHAR_W-1:0] address_match_character,
  input wire logic rx_char_valid,
  input usrc_pkg::usrc_rx_char_t rx_char,
  input wire logic rx_perr_in,
  input wire logic rx_enable_set,
  input wire logic rx_enable_clr,
  output logic uart_clk_en,
  output logic baud_clk_en,
  output logic asleep,
  output logic low_power_active,
  output logic host_isolate,
  output logic rts_n,
  output logic rx_enabled,
  output logic rx_push_valid,
  output usrc_pkg::usrc_push_t rx_push,
  output logic line_irq
);
  import usrc_pkg::*;

  if (IDLE_CHARS < 1) begin : g_chk
    $error("usrc_ctrl: IDLE_CHARS must be at least one");
  end

  usrc_state_t state_reg;
  usrc_state_t state_next;
  logic [USRC_MODEM_W-1:0] modem_prev_reg;
  logic rx_prev_reg;
  logic tx_busy_reg;
  logic rts_n_reg;
  logic rx_enabled_reg;
  logic push_valid_reg;
  usrc_push_t push_reg;
  logic line_irq_reg;
  logic rx_idle;
  logic host_ok;
  logic host_write;
  logic modem_change;
  logic start_bit;
  logic wake_evt;
  logic sleep_allowed;
  logic rx_ok;
  logic sleep_conds;
  logic md_normal;
  logic md_auto;
  logic is_addr;
  logic addr_match;

  // Decides whether a received character is an address in multidrop mode
  function automatic logic addr_char(input logic md, input usrc_rx_char_t c);
    addr_char = md && c.ninth;
  endfunction : addr_char

  usrc_idle_timer #(
    .IDLE_CHARS(IDLE_CHARS)
  ) u_idle (
    .clk(clk),
    .resetn(resetn),
    .rx_line(rx_line),
    .char_tick(char_tick),
    .rx_idle(rx_idle)
  );

  // Input edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modem_prev_reg <= '0;
      rx_prev_reg <= 1'h1;
    end else begin
      modem_prev_reg <= modem_in;
      rx_prev_reg <= rx_line;
    end
  end

  // Host strobes are ignored while isolated
  assign host_ok = (state_reg != USRC_ST_LOW_POWER_PIN);
  assign host_write = tx_write && host_ok;

  assign modem_change = (modem_in != modem_prev_reg);
  assign start_bit = rx_prev_reg && !rx_line;
  assign wake_evt = start_bit || host_write || modem_change;

  assign sleep_allowed = cfg.enh_functions_en && cfg.sleep_en;
  assign rx_ok = cfg.rx_idle_ignore || rx_idle;
  assign sleep_conds = !modem_change && tx_fifo_empty && tsr_empty
    && !irq_pending && rx_fifo_empty && rx_ok;

  // Power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      USRC_ST_RUN: begin
        if (low_power_pin) begin
          state_next = USRC_ST_LOW_POWER_PIN;
        end else if (sleep_allowed && sleep_conds && !wake_evt) begin
          state_next = USRC_ST_SLEEP;
        end
      end
      USRC_ST_SLEEP: begin
        if (low_power_pin) begin
          state_next = USRC_ST_LOW_POWER_PIN;
        end else if (wake_evt || !sleep_allowed) begin
          state_next = USRC_ST_RUN;
        end
      end
      USRC_ST_LOW_POWER_PIN: begin
        if (!low_power_pin) begin
          state_next = USRC_ST_RUN;
        end
      end
      default: begin
        state_next = USRC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= USRC_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Clock gates follow the power state
  assign asleep = (state_reg == USRC_ST_SLEEP);
  assign low_power_active = (state_reg == USRC_ST_LOW_POWER_PIN);
  assign uart_clk_en = (state_reg == USRC_ST_RUN);
  assign baud_clk_en = (state_reg == USRC_ST_RUN);
  assign host_isolate = low_power_active;

  // Transmitter holds data from the write until the shifter drains
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_busy_reg <= 1'h0;
    end else if (host_write) begin
      tx_busy_reg <= 1'h1;
    end else if (tx_fifo_empty && tsr_empty) begin
      tx_busy_reg <= 1'h0;
    end
  end

  // RTS pin source selection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rts_n_reg <= USRC_RESET_RTS_N;
    end else if (cfg.rts_auto_en) begin
      if (cfg.rts_invert) begin
        rts_n_reg <= host_write || tx_busy_reg;
      end else begin
        rts_n_reg <= !(host_write || tx_busy_reg);
      end
    end else if (hw_flow_en) begin
      rts_n_reg <= hw_flow_rts_n;
    end else begin
      rts_n_reg <= !mcr_rts;
    end
  end

  assign rts_n = rts_n_reg;

  // Multidrop classification
  assign md_normal = cfg.multidrop_en && !cfg.spec_char_en
    && (cfg.parity_mode == USRC_LCR_FORCE0);
  assign md_auto = cfg.multidrop_en && cfg.spec_char_en;
  assign is_addr = addr_char(cfg.multidrop_en, rx_char);
  assign addr_match = (rx_char.data == address_match_character);

  // Receiver enable; hardware address events win over host strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_enabled_reg <= 1'h0;
    end else if (rx_char_valid && md_auto && is_addr) begin
      rx_enabled_reg <= addr_match;
    end else if (host_ok && rx_enable_set) begin
      rx_enabled_reg <= 1'h1;
    end else if (host_ok && rx_enable_clr) begin
      rx_enabled_reg <= 1'h0;
    end
  end

  assign rx_enabled = rx_enabled_reg;

  // Receive FIFO push and line status request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      push_valid_reg <= 1'h0;
      push_reg <= '0;
      line_irq_reg <= 1'h0;
    end else begin
      push_valid_reg <= 1'h0;
      line_irq_reg <= 1'h0;
      push_reg.data <= rx_char.data;
      push_reg.perr <= rx_perr_in;
      if (rx_char_valid) begin
        if (md_auto) begin
          if (is_addr) begin
            push_valid_reg <= addr_match;
            push_reg.perr <= rx_char.ninth;
            line_irq_reg <= addr_match && cfg.line_irq_en;
          end else begin
            push_valid_reg <= rx_enabled_reg;
          end
        end else if (md_normal) begin
          if (is_addr) begin
            push_valid_reg <= 1'h1;
            push_reg.perr <= 1'h1;
            line_irq_reg <= cfg.line_irq_en;
          end else begin
            push_valid_reg <= rx_enabled_reg;
          end
        end else begin
          push_valid_reg <= 1'h1;
        end
      end
    end
  end

  assign rx_push_valid = push_valid_reg;
  assign rx_push = push_reg;
  assign line_irq = line_irq_reg;

  // Checks
  a_sleep_entry_gate: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(asleep) |-> $past(cfg.enh_functions_en && cfg.sleep_en))
    else $error("sleep entered without both enables");

  a_sleep_entry_empty: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(asleep) |-> $past(tx_fifo_empty && tsr_empty && rx_fifo_empty
      && !irq_pending && modem_in == modem_prev_reg))
    else $error("sleep entered with work pending");

  a_sleep_rx_idle: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(asleep) && !$past(cfg.rx_idle_ignore) |-> $past(rx_idle))
    else $error("sleep entered before receive line idle");

  a_sleep_clk_stop: assert property (
    @(posedge clk) disable iff (!resetn)
    asleep |-> !uart_clk_en && !baud_clk_en)
    else $error("clocks running while asleep");

  a_wake_tx_write: assert property (
    @(posedge clk) disable iff (!resetn)
    asleep && tx_write && !low_power_pin |=> uart_clk_en)
    else $error("transmit write did not wake");

  a_sleep_disable: assert property (
    @(posedge clk) disable iff (!resetn)
    asleep && !cfg.sleep_en && !low_power_pin |=> !asleep)
    else $error("sleep kept after enable cleared");

  a_low_power_pin_stop_clk: assert property (
    @(posedge clk) disable iff (!resetn)
    low_power_pin ##1 low_power_pin |-> !uart_clk_en && host_isolate)
    else $error("low power pin did not stop clocks");

  a_low_power_pin_release: assert property (
    @(posedge clk) disable iff (!resetn)
    low_power_active && !low_power_pin |=> uart_clk_en)
    else $error("low power release did not resume");

  a_rts_manual: assert property (
    @(posedge clk) disable iff (!resetn)
    !cfg.rts_auto_en && !hw_flow_en |=> rts_n == !$past(mcr_rts))
    else $error("RTS does not follow modem control bit");

  a_rts_auto_low: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg.rts_auto_en && !cfg.rts_invert && tx_write && host_ok
      ##1 cfg.rts_auto_en && !cfg.rts_invert |-> !rts_n)
    else $error("RTS not asserted on transmit write");

  a_rts_invert_high: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg.rts_auto_en && cfg.rts_invert && tx_busy_reg |=> rts_n)
    else $error("inverted RTS low while data pending");

  a_addr_normal: assert property (
    @(posedge clk) disable iff (!resetn)
    rx_char_valid && md_normal && rx_char.ninth
      |=> rx_push_valid && rx_push.perr
        && line_irq == $past(cfg.line_irq_en))
    else $error("address byte not flagged in normal multidrop");

  a_data_drop: assert property (
    @(posedge clk) disable iff (!resetn)
    rx_char_valid && (md_normal || md_auto) && !rx_char.ninth
      && !rx_enabled |=> !rx_push_valid)
    else $error("data byte stored while receiver disabled");

  a_auto_mismatch: assert property (
    @(posedge clk) disable iff (!resetn)
    rx_char_valid && md_auto && rx_char.ninth && !addr_match
      |=> !rx_push_valid && !rx_enabled)
    else $error("mismatching address not dropped");

  a_auto_match: assert property (
    @(posedge clk) disable iff (!resetn)
    rx_char_valid && md_auto && rx_char.ninth && addr_match
      |=> rx_push_valid && rx_push.perr && rx_enabled)
    else $error("matching address not stored");

  c_sleep_enter: cover property (
    @(posedge clk) disable iff (!resetn) $rose(asleep));

  c_wake_resleep: cover property (
    @(posedge clk) disable iff (!resetn)
    asleep ##1 !asleep ##[1:100] asleep);

  c_low_power_pin: cover property (
    @(posedge clk) disable iff (!resetn)
    low_power_active ##1 !low_power_active);

  c_auto_match: cover property (
    @(posedge clk) disable iff (!resetn)
    rx_char_valid && md_auto && rx_char.ninth && addr_match);

endmodule : usrc_ctrl

//--- usrc_station.sv
// Far RS-485 station model driving the receive side
module usrc_station
  import usrc_pkg::*;
(
  input wire logic clk,
  output logic rx_line,
  output logic rx_char_valid,
  output usrc_pkg::usrc_rx_char_t rx_char
);
  initial begin
    rx_line = 1'h1;
    rx_char_valid = 1'h0;
    rx_char = '0;
  end

  // Start bit on the line, then the framed character
  task automatic send(input logic [7:0] d, input logic n);
    @(posedge clk);
    rx_line <= 1'h0;
    @(posedge clk);
    rx_line <= 1'h1;
    rx_char_valid <= 1'h1;
    rx_char <= '{data: d, ninth: n};
    @(posedge clk);
    rx_char_valid <= 1'h0;
    rx_char <= '{data: ~d, ninth: ~n};
  endtask : send
endmodule : usrc_station

//--- uart_sleep_rs485_control_tb_top.sv
// Testbench for the sleep, RS-485 RTS and multidrop control
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("mismatch %s exp %h got %h", nm, ex, got); error_cnt++; end end
module uart_sleep_rs485_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import usrc_pkg::*;
  logic clk, resetn, low_power_pin, char_tick, tx_write, tx_fifo_empty;
  logic tsr_empty, irq_pending, rx_fifo_empty, mcr_rts, hw_flow_en;
  logic hw_flow_rts_n, rx_perr_in, rx_enable_set, rx_enable_clr;
  logic rx_line, rx_char_valid, uart_clk_en, baud_clk_en, asleep;
  logic low_power_active, host_isolate, rts_n, rx_enabled, rx_push_valid;
  logic line_irq;
  usrc_cfg_t cfg;
  logic [USRC_MODEM_W-1:0] modem_in;
  logic [USRC_CHAR_W-1:0] address_match_character;
  usrc_rx_char_t rx_char;
  usrc_push_t rx_push;
  int error_cnt = 0;
  int check_count = 0;

  usrc_ctrl usrc_ctrl_i (.clk(clk), .resetn(resetn), .cfg(cfg),
    .low_power_pin(low_power_pin), .modem_in(modem_in), .rx_line(rx_line),
    .char_tick(char_tick), .tx_write(tx_write),
    .tx_fifo_empty(tx_fifo_empty), .tsr_empty(tsr_empty),
    .irq_pending(irq_pending), .rx_fifo_empty(rx_fifo_empty),
    .mcr_rts(mcr_rts), .hw_flow_en(hw_flow_en),
    .hw_flow_rts_n(hw_flow_rts_n),
    .address_match_character(address_match_character),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_perr_in(rx_perr_in), .rx_enable_set(rx_enable_set),
    .rx_enable_clr(rx_enable_clr), .uart_clk_en(uart_clk_en),
    .baud_clk_en(baud_clk_en), .asleep(asleep),
    .low_power_active(low_power_active), .host_isolate(host_isolate),
    .rts_n(rts_n), .rx_enabled(rx_enabled),
    .rx_push_valid(rx_push_valid), .rx_push(rx_push), .line_irq(line_irq));

  usrc_station usrc_station_i (.clk(clk), .rx_line(rx_line),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char));

  always #25 clk = ~clk;

  task automatic results();
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wait_sleep(input logic want);
    for (int i = 0; i < 60 && asleep !== want; i++) cyc(1);
    `CHK("asleep", want, asleep)
    if (asleep !== want) results();
  endtask : wait_sleep

  task automatic wr_tx();
    @(posedge clk);
    tx_write <= 1'h1;
    @(posedge clk);
    tx_write <= 1'h0;
    #1;
  endtask : wr_tx

  task automatic tick();
    @(posedge clk);
    char_tick <= 1'h1;
    @(posedge clk);
    char_tick <= 1'h0;
  endtask : tick

  task automatic host_en(input logic s);
    @(posedge clk);
    rx_enable_set <= s;
    rx_enable_clr <= ~s;
    @(posedge clk);
    rx_enable_set <= 1'h0;
    rx_enable_clr <= 1'h0;
    #1;
    `CHK("rx_enabled", s, rx_enabled)
  endtask : host_en

  // Address characters carry perr and raise the line interrupt
  task automatic rx(input logic [7:0] d, input logic n, input logic push);
    usrc_station_i.send(d, n);
    #1;
    `CHK("push_valid", push, rx_push_valid)
    if (push) begin
      `CHK("push_data", d, rx_push.data)
      `CHK("push_perr", n, rx_push.perr)
      `CHK("line_irq", n, line_irq)
    end
  endtask : rx

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    clk = 1'h0;
    resetn = 1'h0;
    cfg = '0;
    {low_power_pin, char_tick, tx_write, irq_pending, mcr_rts} = '0;
    {hw_flow_en, rx_perr_in, rx_enable_set, rx_enable_clr} = '0;
    {tx_fifo_empty, tsr_empty, rx_fifo_empty, hw_flow_rts_n} = 4'hf;
    modem_in = '0;
    address_match_character = 8'h5a;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    cyc(1);
    `CHK("asleep", 1'h0, asleep)
    `CHK("uart_clk_en", 1'h1, uart_clk_en)
    `CHK("rts_n", USRC_RESET_RTS_N, rts_n)
    `CHK("rx_enabled", 1'h0, rx_enabled)
    cfg.sleep_en <= 1'h1;
    cyc(10);
    `CHK("asleep", 1'h0, asleep)
    cfg.enh_functions_en <= 1'h1;
    repeat (3) tick();
    cyc(4);
    `CHK("asleep", 1'h0, asleep)
    tick();
    wait_sleep(1'h1);
    `CHK("uart_clk_en", 1'h0, uart_clk_en)
    `CHK("baud_clk_en", 1'h0, baud_clk_en)
    cfg.rx_idle_ignore <= 1'h1;
    wr_tx();
    `CHK("asleep", 1'h0, asleep)
    wait_sleep(1'h1);
    @(posedge clk);
    modem_in <= 4'h1;
    cyc(1);
    `CHK("asleep", 1'h0, asleep)
    wait_sleep(1'h1);
    fork
      usrc_station_i.send(8'h00, 1'h0);
      begin
        cyc(2);
        `CHK("asleep", 1'h0, asleep)
      end
    join
    wait_sleep(1'h1);
    irq_pending <= 1'h1;
    wr_tx();
    cyc(8);
    `CHK("asleep", 1'h0, asleep)
    irq_pending <= 1'h0;
    wait_sleep(1'h1);
    // Sleep enable cleared; the UART wakes and stays awake
    cfg.sleep_en <= 1'h0;
    cyc(8);
    `CHK("asleep", 1'h0, asleep)
    low_power_pin <= 1'h1;
    cyc(1);
    `CHK("low_power", 1'h1, low_power_active)
    `CHK("host_isolate", 1'h1, host_isolate)
    `CHK("uart_clk_en", 1'h0, uart_clk_en)
    `CHK("baud_clk_en", 1'h0, baud_clk_en)
    low_power_pin <= 1'h0;
    cyc(1);
    `CHK("low_power", 1'h0, low_power_active)
    `CHK("uart_clk_en", 1'h1, uart_clk_en)
    mcr_rts <= 1'h1;
    cyc(2);
    `CHK("rts_n", 1'h0, rts_n)
    hw_flow_en <= 1'h1;
    cyc(2);
    `CHK("rts_n", 1'h1, rts_n)
    hw_flow_en <= 1'h0;
    cfg.rts_auto_en <= 1'h1;
    for (int inv = 0; inv < 2; inv++) begin
      @(posedge clk);
      cfg.rts_invert <= inv[0];
      tx_fifo_empty <= 1'h0;
      cyc(2);
      `CHK("rts_idle", ~inv[0], rts_n)
      wr_tx();
      cyc(1);
      `CHK("rts_busy", inv[0], rts_n)
      tx_fifo_empty <= 1'h1;
      cyc(4);
      `CHK("rts_done", ~inv[0], rts_n)
    end
    // Flow control left off for multidrop
    cfg.multidrop_en <= 1'h1;
    cfg.parity_mode <= USRC_LCR_FORCE0;
    cfg.line_irq_en <= 1'h1;
    rx(8'h11, 1'h0, 1'h0);
    rx(8'h5a, 1'h1, 1'h1);
    host_en(1'h1);
    rx(8'h22, 1'h0, 1'h1);
    rx(8'h33, 1'h1, 1'h1);
    host_en(1'h0);
    rx(8'h44, 1'h0, 1'h0);
    cfg.spec_char_en <= 1'h1;
    rx(8'h10, 1'h0, 1'h0);
    rx(8'h5b, 1'h1, 1'h0);
    rx(8'h5a, 1'h1, 1'h1);
    `CHK("rx_enabled", 1'h1, rx_enabled)
    rx(8'h20, 1'h0, 1'h1);
    rx(8'h5a, 1'h1, 1'h1);
    rx(8'h5c, 1'h1, 1'h0);
    `CHK("rx_enabled", 1'h0, rx_enabled)
    rx(8'h30, 1'h0, 1'h0);
    results();
  end
endmodule : uart_sleep_rs485_control_tb_top
